/* verif/ata_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host side: task-file writer and stream sink.
module ata_host_model (
	input  wire         clk_i,
	input  wire         busy_i,
	input  wire  [15:0] data_i,
	input  wire         valid_i,
	input  wire  [1:0]  mode_i,
	output logic        tf_wr_o,
	output logic [2:0]  tf_addr_o,
	output logic [7:0]  tf_data_o,
	output logic        ready_o
);
	logic [15:0] words [0:255];
	int          n_words;
	initial begin
		tf_wr_o = 1'b0;
		tf_addr_o = 3'h0;
		tf_data_o = 8'h00;
		ready_o = 1'b0;
		n_words = 0;
	end
	// Mode 0 takes every word, 1 stalls every other cycle, 2 stalls throughout.
	always @(posedge clk_i) begin
		if (valid_i && ready_o) begin
			words[n_words[7:0]] = data_i;
			n_words++;
		end
		#1;
		ready_o = (mode_i == 2'h0) || (mode_i == 2'h1 && !ready_o);
	end
	task automatic wr(input [2:0] addr, input [7:0] dat, input obey);
		@(posedge clk_i);
		#1;
		while (obey && busy_i) begin
			@(posedge clk_i);
			#1;
		end
		tf_wr_o = 1'b1;
		tf_addr_o = addr;
		tf_data_o = dat;
		@(posedge clk_i);
		#1;
		tf_wr_o = 1'b0;
		// A released bus must not look like it still holds the last byte.
		tf_data_o = ~dat;
	endtask
endmodule // ata_host_model

/* verif/ata_responder_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// Port checks for the command responder.
module ata_responder_checker #(
	parameter [15:0] GEN_CONFIG = 16'h5a5a
) (
	input wire        REF_CLK_I,
	input wire        RST_I,
	input wire        TF_WR_I,
	input wire [2:0]  TF_ADDR_I,
	input wire [7:0]  TF_DATA_I,
	input wire        SPARE_LOW_I,
	input wire [15:0] DATA_O,
	input wire        DATA_VALID_O,
	input wire        BUSY_O,
	input wire        ERR_O,
	input wire        ABORT_O,
	input wire        HEALTH_ON_O,
	input wire [8:0]  SECTOR_COUNT_O,
	input wire [3:0]  HEAD_O,
	input wire [7:0]  CYL_LOW_O,
	input wire [7:0]  CYL_HIGH_O
);
	reg  [7:0] feat_reg;
	wire       take = TF_WR_I && !BUSY_O;
	wire [3:0] head_in = TF_DATA_I[3:0];
	// Shadow of the feature register, since commands are judged on it.
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			feat_reg <= 8'h00;
		end else if (take && TF_ADDR_I == 3'h1) begin
			feat_reg <= TF_DATA_I;
		end
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_health;
		take && TF_ADDR_I == 3'h7 && TF_DATA_I == 8'hb0;
	endsequence
	// An empty output stage means no older words can come first.
	sequence s_ident;
		take && !DATA_VALID_O && TF_ADDR_I == 3'h7 && TF_DATA_I == 8'hec;
	endsequence
	AST_COUNT_ZERO: assert property (take && TF_ADDR_I == 3'h2 && TF_DATA_I == 8'h00
		|=> SECTOR_COUNT_O == 9'h100) else $error("count 00h not 256");
	AST_COUNT_LIT: assert property (take && TF_ADDR_I == 3'h2 && TF_DATA_I != 8'h00
		|=> SECTOR_COUNT_O == {1'b0, $past(TF_DATA_I)}) else $error("count not literal");
	AST_HEAD: assert property (take && TF_ADDR_I == 3'h6
		|=> HEAD_O == $past(head_in)) else $error("head field wrong");
	AST_RET_STATUS: assert property (s_health ##0 (feat_reg == 8'hda && HEALTH_ON_O)
		|=> CYL_LOW_O == ($past(SPARE_LOW_I) ? 8'hf4 : 8'h4f)
		&& CYL_HIGH_O == ($past(SPARE_LOW_I) ? 8'h2c : 8'hc2)) else $error("status wrong");
	AST_BAD_SUB: assert property (s_health ##0
		!(feat_reg inside {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8, 8'hd9, 8'hda})
		|=> ERR_O && ABORT_O) else $error("bad subcode not aborted");
	AST_REFUSED_OFF: assert property (s_health ##0 (!HEALTH_ON_O && feat_reg == 8'hda)
		|=> ERR_O && ABORT_O) else $error("disabled status not refused");
	AST_ENABLE: assert property (s_health ##0 feat_reg == 8'hd8
		|=> HEALTH_ON_O && !ERR_O) else $error("enable failed");
	AST_DISABLE: assert property (s_health ##0 feat_reg == 8'hd9
		|=> !HEALTH_ON_O [*2]) else $error("disable failed");
	AST_IDENT: assert property (s_ident |=> BUSY_O ##2
		(DATA_VALID_O && DATA_O == GEN_CONFIG)) else $error("word 0 wrong");
endmodule // ata_responder_checker

bind ata_smart_identify_responder ata_responder_checker #(.GEN_CONFIG(GEN_CONFIG))
	ata_responder_checker_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .TF_WR_I(TF_WR_I),
	.TF_ADDR_I(TF_ADDR_I), .TF_DATA_I(TF_DATA_I), .SPARE_LOW_I(SPARE_LOW_I),
	.DATA_O(DATA_O), .DATA_VALID_O(DATA_VALID_O), .BUSY_O(BUSY_O), .ERR_O(ERR_O),
	.ABORT_O(ABORT_O), .HEALTH_ON_O(HEALTH_ON_O), .SECTOR_COUNT_O(SECTOR_COUNT_O),
	.HEAD_O(HEAD_O), .CYL_LOW_O(CYL_LOW_O), .CYL_HIGH_O(CYL_HIGH_O));

/* verif/ata_smart_identify_responder_tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the command responder.
module ata_smart_identify_responder_tb_top;
	localparam [31:0] TOTAL = 32'h0012_3456;
	localparam [79:0] MU    = {40'h44_33_22_5566, 40'h0d_0c_0b_0a09};
	logic        ref_clk;
	logic        rst;
	logic        mem_mode;
	logic        spare_low;
	logic [1:0]  host_mode;
	wire         tf_wr, data_valid, data_ready, busy, err, abort, health_on;
	wire  [2:0]  tf_addr;
	wire  [7:0]  tf_data, cyl_low, cyl_high;
	wire  [15:0] data;
	wire  [8:0]  sector_count;
	wire  [3:0]  head;
	wire  [7:0]  start_sector;
	logic [79:0] mu_info;
	int          n_fail, total_checks, cycles;
	ata_smart_identify_responder #(.TOTAL_SECT(TOTAL),
		.FW_STR("ABCDEFGH"), .OFF_TIME_SEC(16'h1234), .POLL_SHORT(8'h03),
		.POLL_EXT(8'h05), .POLL_CONV(8'h07)) ata_smart_identify_responder_i (
		.REF_CLK_I(ref_clk), .RST_I(rst), .TF_WR_I(tf_wr), .TF_ADDR_I(tf_addr),
		.TF_DATA_I(tf_data), .MEM_MODE_I(mem_mode), .SPARE_LOW_I(spare_low),
		.MU_INFO_I(mu_info), .DATA_O(data), .DATA_VALID_O(data_valid),
		.DATA_READY_I(data_ready), .BUSY_O(busy), .ERR_O(err), .ABORT_O(abort),
		.HEALTH_ON_O(health_on), .SECTOR_COUNT_O(sector_count), .HEAD_O(head),
		.START_SECTOR_O(start_sector), .CYL_LOW_O(cyl_low), .CYL_HIGH_O(cyl_high));
	ata_host_model ata_host_model_i (.clk_i(ref_clk), .busy_i(busy), .data_i(data),
		.valid_i(data_valid), .mode_i(host_mode), .tf_wr_o(tf_wr), .tf_addr_o(tf_addr),
		.tf_data_o(tf_data), .ready_o(data_ready));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] hb(input int i);
		logic [15:0] w;
		w = ata_host_model_i.words[i / 2];
		hb = i[0] ? w[15:8] : w[7:0];
	endfunction
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input [2:0] a, input [7:0] d, input obey);
		ata_host_model_i.wr(a, d, obey);
		step();
	endtask
	task automatic drain();
		for (int k = 0; k < 4000 && ata_host_model_i.n_words < 256; k++) begin
			@(posedge ref_clk);
		end
		repeat (20) step();
		check("words", 16'(ata_host_model_i.n_words), 16'h0100);
		check("busy", busy, 1'b0);
	endtask
	task automatic cmd(input [7:0] feat, input [7:0] code, input logic dcmd);
		ata_host_model_i.n_words = 0;
		ata_host_model_i.wr(3'h1, feat, 1'b1);
		wr(3'h7, code, 1'b1);
		if (dcmd) drain();
	endtask
	task automatic sum_zero();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 512; i++) s += hb(i);
		check("sum", s, 8'h00);
	endtask
	task automatic t_params();
		wr(3'h2, 8'h00, 1'b1);
		check("count", sector_count, 9'h100);
		wr(3'h2, 8'hff, 1'b1);
		check("count", sector_count, 9'h0ff);
		wr(3'h6, 8'ha5, 1'b1);
		check("head", head, 4'h5);
		wr(3'h3, 8'h5c, 1'b1);
		check("sector", start_sector, 8'h5c);
	endtask
	task automatic t_subcodes();
		cmd(8'hd9, 8'hb0, 1'b0);
		check("on", health_on, 1'b0);
		cmd(8'hda, 8'hb0, 1'b0);
		check("err", {err, abort}, 2'h3);
		cmd(8'hd0, 8'hb0, 1'b0);
		check("err", {err, abort}, 2'h3);
		cmd(8'hd8, 8'hb0, 1'b0);
		check("on", {health_on, err}, 2'h2);
		spare_low = 1'b0;
		cmd(8'hda, 8'hb0, 1'b0);
		check("cyl", {cyl_high, cyl_low}, 16'hc24f);
		spare_low = 1'b1;
		cmd(8'hda, 8'hb0, 1'b0);
		check("cyl", {cyl_high, cyl_low}, 16'h2cf4);
		cmd(8'hd2, 8'hb0, 1'b0);
		check("err", err, 1'b0);
		cmd(8'hd3, 8'hb0, 1'b0);
		check("err", err, 1'b0);
		cmd(8'hd5, 8'hb0, 1'b0);
		check("err", {err, abort}, 2'h3);
		cmd(8'hd1, 8'hb0, 1'b1);
		sum_zero();
	endtask
	// With the sink stalled the queue fills and the write path must refuse.
	task automatic t_health(input [7:0] st, input logic stall);
		host_mode = stall ? 2'h2 : 2'h0;
		ata_host_model_i.n_words = 0;
		ata_host_model_i.wr(3'h1, 8'hd0, 1'b1);
		ata_host_model_i.wr(3'h7, 8'hb0, 1'b1);
		if (stall) begin
			repeat (40) step();
			check("full", {busy, data_valid}, 2'h3);
			wr(3'h2, 8'h07, 1'b0);
			check("count", sector_count, 9'h0ff);
			host_mode = 2'h1;
		end
		drain();
		check("b362", hb(362), st);
		check("b364", {hb(364), hb(365)}, 16'h1234);
		check("b367", hb(367), 8'h01);
		check("b368", {hb(368), hb(369)}, 16'h0003);
		check("b370", hb(370), 8'h01);
		check("b372", hb(372), 8'h03);
		check("b373", {hb(373), hb(374)}, 16'h0507);
		for (int i = 375; i < 386; i++) check("rsvd", hb(i), 8'h00);
		check("b396", hb(396), 8'h02);
		for (int n = 0; n < 2; n++) begin
			check("unit", hb(397 + 6 * n), n[7:0]);
			check("dblk", {hb(398+6*n), hb(399+6*n)}, mu_info[40*n +: 16]);
			check("rec", {hb(401+6*n), hb(400+6*n)}, mu_info[40*n+16 +: 16]);
			check("rt", hb(402+6*n), mu_info[40*n+32 +: 8]);
		end
		sum_zero();
		host_mode = 2'h0;
	endtask
	task automatic ci(input int w, input logic [15:0] e);
		check("id word", ata_host_model_i.words[w], e);
	endtask
	task automatic t_identify(input logic mem);
		mem_mode = mem;
		repeat (4) step();
		wr(3'h2, 8'h20, 1'b1);
		cmd(8'h00, 8'h91, 1'b0);
		cmd(8'h00, 8'hec, 1'b1);
		ci(0, 16'h5a5a);
		ci(7, TOTAL[31:16]);
		ci(8, TOTAL[15:0]);
		ci(22, 16'h0004);
		ci(23, 16'h4142);
		ci(26, 16'h4748);
		ci(47, 16'h8001);
		ci(59, 16'h0101);
		ci(49, 16'h0300);
		ci(51, 16'h0200);
		ci(53, 16'h0007);
		ci(54, 16'h03d0);
		ci(55, 16'h0006);
		ci(56, 16'h0020);
		ci(57, TOTAL[15:0]);
		ci(58, TOTAL[31:16]);
		ci(60, TOTAL[15:0]);
		ci(61, TOTAL[31:16]);
		ci(63, mem ? 16'h0000 : 16'h0007);
		ci(64, 16'h0003);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// The ceiling sits well above the longest stalled stream run.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		rst = 1'b1;
		mem_mode = 1'b0;
		spare_low = 1'b0;
		host_mode = 2'h0;
		mu_info = MU;
		repeat (4) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_params();
		t_health(8'h00, 1'b1);
		t_subcodes();
		cmd(8'hd4, 8'hb0, 1'b0);
		// Swapped unit records catch a record indexed by the wrong unit.
		mu_info = {MU[39:0], MU[79:40]};
		t_health(8'h02, 1'b0);
		t_identify(1'b0);
		t_identify(1'b1);
		finish_test();
	end
endmodule // ata_smart_identify_responder_tb_top

/* verilog/ata_responder_consts.vh */
`ifndef ATA_RESPONDER_CONSTS_VH
`define ATA_RESPONDER_CONSTS_VH
// ==========================================================================
// Task-file register addresses.
`define TF_FEATURE       3'h1
`define TF_COUNT         3'h2
`define TF_SECTOR        3'h3
`define TF_CYL_LOW       3'h4
`define TF_CYL_HIGH      3'h5
`define TF_DRIVE_HEAD    3'h6
`define TF_COMMAND       3'h7
// ==========================================================================
// Command codes and health subcodes.
`define CMD_IDENTIFY     8'hec
`define CMD_HEALTH       8'hb0
`define CMD_INIT_PARAMS  8'h91
`define SUB_READ_DATA    8'hd0
`define SUB_READ_THRESH  8'hd1
`define SUB_AUTOSAVE     8'hd2
`define SUB_SAVE_ATTR    8'hd3
`define SUB_OFFLINE_NOW  8'hd4
`define SUB_ENABLE       8'hd8
`define SUB_DISABLE      8'hd9
`define SUB_RET_STATUS   8'hda
// ==========================================================================
// Status answers in the cylinder registers.
`define CYL_LOW_GOOD     8'h4f
`define CYL_HIGH_GOOD    8'hc2
`define CYL_LOW_LOW      8'hf4
`define CYL_HIGH_LOW     8'h2c
// ==========================================================================
// Sector count and head field.
`define COUNT_ZERO       8'h00
`define COUNT_FULL       9'h100
`define HEAD_LSB         0
`define HEAD_MSB         3
// ==========================================================================
// Identify words.
`define ID_W_CONFIG      8'h00
`define ID_W_CYL         8'h01
`define ID_W_HEADS       8'h03
`define ID_W_SPT         8'h06
`define ID_W_TOT_MSW     8'h07
`define ID_W_TOT_LSW     8'h08
`define ID_W_SER_FIRST   8'h0a
`define ID_W_SER_LAST    8'h13
`define ID_W_CHECK       8'h16
`define ID_W_FW_FIRST    8'h17
`define ID_W_FW_LAST     8'h1a
`define ID_W_MOD_FIRST   8'h1b
`define ID_W_MOD_LAST    8'h2e
`define ID_W_MULT_MAX    8'h2f
`define ID_W_CAPS        8'h31
`define ID_W_PIO         8'h33
`define ID_W_VALID       8'h35
`define ID_W_CUR_CYL     8'h36
`define ID_W_CUR_HEADS   8'h37
`define ID_W_CUR_SPT     8'h38
`define ID_W_CAP_LSW     8'h39
`define ID_W_CAP_MSW     8'h3a
`define ID_W_MULT_SET    8'h3b
`define ID_W_LBA_LSW     8'h3c
`define ID_W_LBA_MSW     8'h3d
`define ID_W_DMA         8'h3f
`define ID_W_ADV_PIO     8'h40
`define ID_V_CHECK       16'h0004
`define ID_V_MULT_MAX    16'h8001
`define ID_V_CAPS        16'h0300
`define ID_V_PIO         16'h0200
`define ID_V_VALID       16'h0007
`define ID_V_MULT_SET    16'h0101
`define ID_V_DMA         16'h0007
`define ID_V_ADV_PIO     16'h0003
// ==========================================================================
// Health structure bytes.
`define HB_REV_MSB       9'h000
`define HB_REV_LSB       9'h001
`define HB_OFF_STATUS    9'h16a
`define HB_OFF_TIME_MSB  9'h16c
`define HB_OFF_TIME_LSB  9'h16d
`define HB_OFF_CAP       9'h16f
`define HB_MON_CAP_MSB   9'h170
`define HB_MON_CAP_LSB   9'h171
`define HB_ERR_LOG       9'h172
`define HB_POLL_SHORT    9'h174
`define HB_POLL_EXT      9'h175
`define HB_POLL_CONV     9'h176
`define HB_FW_FIRST      9'h182
`define HB_FW_LAST       9'h18b
`define HB_MU_COUNT      9'h18c
`define HB_MU_BASE       397
`define HB_MU_STRIDE     6
`define HB_REVISION      16'h0001
`define HB_V_OFF_CAP     8'h01
`define HB_V_MON_CAP     16'h0003
`define HB_V_ERR_LOG     8'h01
`define OFF_DONE         8'h02
`define WORD_LAST        8'hff
`endif

/* verilog/ata_smart_identify_responder.v */
`timescale 1ns/1ps
// Function
// - Transfer length 00h means 256 sectors, other values are literal counts.
// - Head number comes from the low four bits of drive/head select.
// - Health subcodes D0h-D4h, D8h, D9h, DAh are decoded to their actions.
// - Return status reports spare capacity below threshold in cylinder registers.
// - All reserved health bytes, including 375 to 385, read as zero.
// - Fixed capability bytes 367, 368-369 never change.
// - Unit count at byte 396, unit index at byte 397 plus six per unit.
// - Unit record holds data, spare and runtime bad counts.
// - Multi-byte health values are sent most significant byte first, except the unit record's second 16-bit count, sent low byte first.
// - Byte 370 reports error logging supported in bit 0, rest zero.
// - Bytes 372-374 give short, extended and conveyance polling minutes.
// - Byte 362 gives offline status, 364-365 total offline time in seconds.
// - Identify words 7 and 8 give total sectors, word 7 high half.
// - Identify words 57 and 58 give current capacity, word 57 low half.
// - Serial, firmware and model strings, big-endian bytes within each word.
// - Word 47 reads 8001h and word 59 reads 0101h.
// - Words 49, 51 and 53 read 0300h, 0200h and 0007h.
// - Word 63 reads 0007h, but zero in memory card mode.
// - Word 64 reads 0003h for advanced PIO modes.
// - Word 22 reads 0004h check bytes for long commands.
// - Words 60 and 61 give total sectors addressable by block address.
// - Words 54, 55, 56 give current cylinders, heads, sectors per track.
`include "ata_responder_consts.vh"

// ==========================================================================
// Word FIFO with a registered output stage.
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output reg  [WIDTH-1:0] out_data_o,
	output reg              out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_reg;
	reg [AW-1:0]    rd_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;
	wire            load;
	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign push       = in_valid_i && in_ready_o;
	assign load       = !out_valid_o || out_ready_i;
	assign pop        = load && (count_reg != {(AW+1){1'b0}});
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_reg      <= {AW{1'b0}};
			rd_reg      <= {AW{1'b0}};
			count_reg   <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_reg[wr_reg] <= in_data_i;
				wr_reg          <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			end
			if (pop) begin
				out_data_o <= mem_reg[rd_reg];
				rd_reg     <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			end
			if (load)
				out_valid_o <= pop;
			count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // word_fifo

// ==========================================================================
// Command interpreter and data builder.
module ata_smart_identify_responder #(
	parameter         MU_COUNT      = 2,
	parameter         FIFO_DEPTH    = 16,
	parameter         FIFO_AW       = 4,
	parameter [15:0]  GEN_CONFIG    = 16'h5a5a,  // Arbitrary signature value.
	parameter [15:0]  DEF_CYL       = 16'h03d0,
	parameter [15:0]  DEF_HEADS     = 16'h0010,
	parameter [15:0]  DEF_SPT       = 16'h003f,
	parameter [31:0]  TOTAL_SECT    = 32'h000f_0000,
	parameter [159:0] SERIAL_STR    = {20{8'h20}},
	parameter [63:0]  FW_STR        = {8{8'h20}},
	parameter [319:0] MODEL_STR     = {40{8'h20}},
	parameter [79:0]  FW_DATE_STR   = {10{8'h20}},
	parameter [15:0]  OFF_TIME_SEC  = 16'h0000,
	parameter [7:0]   POLL_SHORT    = 8'h01,
	parameter [7:0]   POLL_EXT      = 8'h02,
	parameter [7:0]   POLL_CONV     = 8'h01
) (
	input  wire                 REF_CLK_I,
	input  wire                 RST_I,
	input  wire                 TF_WR_I,
	input  wire [2:0]           TF_ADDR_I,
	input  wire [7:0]           TF_DATA_I,
	input  wire                 MEM_MODE_I,
	input  wire                 SPARE_LOW_I,
	input  wire [MU_COUNT*40-1:0] MU_INFO_I,
	output wire [15:0]          DATA_O,
	output wire                 DATA_VALID_O,
	input  wire                 DATA_READY_I,
	output reg                  BUSY_O,
	output reg                  ERR_O,
	output reg                  ABORT_O,
	output reg                  HEALTH_ON_O,
	output reg  [8:0]           SECTOR_COUNT_O,
	output reg  [3:0]           HEAD_O,
	output reg  [7:0]           START_SECTOR_O,
	output reg  [7:0]           CYL_LOW_O,
	output reg  [7:0]           CYL_HIGH_O
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ID   = 3'b010;
	localparam [2:0] ST_HLTH = 3'b100;
	localparam [15:0] REV_CODE = `HB_REVISION;
	localparam [15:0] MON_CAP  = `HB_V_MON_CAP;

	reg  [2:0]  state_reg;
	reg  [7:0]  feature_reg;
	reg  [7:0]  transfer_length_reg;
	reg  [7:0]  start_sector_reg;
	reg  [7:0]  drive_head_select_reg;
	reg  [7:0]  offline_status_reg;
	reg  [15:0] cur_heads_reg;
	reg  [15:0] cur_spt_reg;
	reg         thresh_reg;
	reg  [7:0]  widx_reg;
	reg  [7:0]  sum_reg;
	reg         mode_meta_reg;
	reg         mode_sync_reg;
	reg  [15:0] word_next;
	reg  [7:0]  lo_byte;
	reg  [7:0]  hi_byte;
	wire        fifo_ready;
	wire        push;
	wire        cmd_wr;

	// ======================================================================
	// The card mode strap is a pin, so it is synchronised before use.
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mode_meta_reg <= 1'b0;
			mode_sync_reg <= 1'b0;
		end else begin
			mode_meta_reg <= MEM_MODE_I;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// ======================================================================
	// Health structure byte map.
	function [7:0] health_byte;
		input [8:0] a;
		integer n;
		integer base;
		begin
			health_byte = 8'h00;
			case (a)
			`HB_REV_MSB:      health_byte = REV_CODE[15:8];
			`HB_REV_LSB:      health_byte = REV_CODE[7:0];
			`HB_OFF_STATUS:   health_byte = offline_status_reg;
			`HB_OFF_TIME_MSB: health_byte = OFF_TIME_SEC[15:8];
			`HB_OFF_TIME_LSB: health_byte = OFF_TIME_SEC[7:0];
			`HB_OFF_CAP:      health_byte = `HB_V_OFF_CAP;
			`HB_MON_CAP_MSB:  health_byte = MON_CAP[15:8];
			`HB_MON_CAP_LSB:  health_byte = MON_CAP[7:0];
			`HB_ERR_LOG:      health_byte = `HB_V_ERR_LOG;
			`HB_POLL_SHORT:   health_byte = POLL_SHORT;
			`HB_POLL_EXT:     health_byte = POLL_EXT;
			`HB_POLL_CONV:    health_byte = POLL_CONV;
			`HB_MU_COUNT:     health_byte = MU_COUNT[7:0];
			default:          health_byte = 8'h00;
			endcase
			if (a >= `HB_FW_FIRST && a <= `HB_FW_LAST)
				health_byte = FW_DATE_STR[79 - 8 * (a - `HB_FW_FIRST) -: 8];
			for (n = 0; n < MU_COUNT; n = n + 1) begin
				base = `HB_MU_BASE + `HB_MU_STRIDE * n;
				if (a == base)
					health_byte = n[7:0];
				if (a == base + 1)
					health_byte = MU_INFO_I[40*n+8 +: 8];
				if (a == base + 2)
					health_byte = MU_INFO_I[40*n +: 8];
				if (a == base + 3)
					health_byte = MU_INFO_I[40*n+16 +: 8];
				if (a == base + 4)
					health_byte = MU_INFO_I[40*n+24 +: 8];
				if (a == base + 5)
					health_byte = MU_INFO_I[40*n+32 +: 8];
			end
		end
	endfunction

	// ======================================================================
	// Identify word map; words not listed read as zero.
	function [15:0] id_word;
		input [7:0] w;
		begin
			case (w)
			`ID_W_CONFIG:    id_word = GEN_CONFIG;
			`ID_W_CYL:       id_word = DEF_CYL;
			`ID_W_HEADS:     id_word = DEF_HEADS;
			`ID_W_SPT:       id_word = DEF_SPT;
			`ID_W_TOT_MSW:   id_word = TOTAL_SECT[31:16];
			`ID_W_TOT_LSW:   id_word = TOTAL_SECT[15:0];
			`ID_W_CHECK:     id_word = `ID_V_CHECK;
			`ID_W_MULT_MAX:  id_word = `ID_V_MULT_MAX;
			`ID_W_CAPS:      id_word = `ID_V_CAPS;
			`ID_W_PIO:       id_word = `ID_V_PIO;
			`ID_W_VALID:     id_word = `ID_V_VALID;
			`ID_W_CUR_CYL:   id_word = DEF_CYL;
			`ID_W_CUR_HEADS: id_word = cur_heads_reg;
			`ID_W_CUR_SPT:   id_word = cur_spt_reg;
			`ID_W_CAP_LSW:   id_word = TOTAL_SECT[15:0];
			`ID_W_CAP_MSW:   id_word = TOTAL_SECT[31:16];
			`ID_W_MULT_SET:  id_word = `ID_V_MULT_SET;
			`ID_W_LBA_LSW:   id_word = TOTAL_SECT[15:0];
			`ID_W_LBA_MSW:   id_word = TOTAL_SECT[31:16];
			`ID_W_DMA:       id_word = mode_sync_reg ? 16'h0000 : `ID_V_DMA;
			`ID_W_ADV_PIO:   id_word = `ID_V_ADV_PIO;
			default:         id_word = 16'h0000;
			endcase
			// The first character of each pair goes to the high byte.
			if (w >= `ID_W_SER_FIRST && w <= `ID_W_SER_LAST)
				id_word = SERIAL_STR[159 - 16 * (w - `ID_W_SER_FIRST) -: 16];
			if (w >= `ID_W_FW_FIRST && w <= `ID_W_FW_LAST)
				id_word = FW_STR[63 - 16 * (w - `ID_W_FW_FIRST) -: 16];
			if (w >= `ID_W_MOD_FIRST && w <= `ID_W_MOD_LAST)
				id_word = MODEL_STR[319 - 16 * (w - `ID_W_MOD_FIRST) -: 16];
		end
	endfunction

	// ======================================================================
	// Word builder; threshold data is all zero, so its checksum byte is zero as well.
	always @* begin
		lo_byte = 8'h00;
		hi_byte = 8'h00;
		if (!thresh_reg) begin
			lo_byte = health_byte({widx_reg, 1'b0});
			hi_byte = health_byte({widx_reg, 1'b1});
		end
		if (widx_reg == `WORD_LAST)
			hi_byte = 8'h00 - sum_reg - lo_byte;
		if (state_reg == ST_ID)
			word_next = id_word(widx_reg);
		else
			word_next = {hi_byte, lo_byte};
	end

	assign push   = (state_reg != ST_IDLE) && fifo_ready;
	assign cmd_wr = TF_WR_I && (TF_ADDR_I == `TF_COMMAND);

	// ======================================================================
	// Task file and command sequencing.
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg             <= ST_IDLE;
			feature_reg           <= 8'h00;
			transfer_length_reg   <= 8'h01;
			start_sector_reg      <= 8'h01;
			drive_head_select_reg <= 8'h00;
			offline_status_reg    <= 8'h00;
			cur_heads_reg         <= DEF_HEADS;
			cur_spt_reg           <= DEF_SPT;
			thresh_reg            <= 1'b0;
			widx_reg              <= 8'h00;
			sum_reg               <= 8'h00;
			BUSY_O                <= 1'b0;
			ERR_O                 <= 1'b0;
			ABORT_O               <= 1'b0;
			HEALTH_ON_O           <= 1'b1;
			SECTOR_COUNT_O        <= 9'h001;
			HEAD_O                <= 4'h0;
			START_SECTOR_O        <= 8'h01;
			CYL_LOW_O             <= 8'h00;
			CYL_HIGH_O            <= 8'h00;
		end else begin
			// Writes while busy are dropped; the host waits for busy low.
			if (TF_WR_I && !BUSY_O) begin
				case (TF_ADDR_I)
				`TF_FEATURE:    feature_reg <= TF_DATA_I;
				`TF_COUNT: begin
					transfer_length_reg <= TF_DATA_I;
					SECTOR_COUNT_O <= (TF_DATA_I == `COUNT_ZERO) ? `COUNT_FULL
						: {1'b0, TF_DATA_I};
				end
				`TF_SECTOR: begin
					start_sector_reg <= TF_DATA_I;
					START_SECTOR_O   <= TF_DATA_I;
				end
				`TF_CYL_LOW:    CYL_LOW_O <= TF_DATA_I;
				`TF_CYL_HIGH:   CYL_HIGH_O <= TF_DATA_I;
				`TF_DRIVE_HEAD: begin
					drive_head_select_reg <= TF_DATA_I;
					HEAD_O <= TF_DATA_I[`HEAD_MSB:`HEAD_LSB];
				end
				default: ;
				endcase
			end
			// Parameters already sit in the task file when the code arrives.
			if (cmd_wr && !BUSY_O) begin
				ERR_O   <= 1'b0;
				ABORT_O <= 1'b0;
				widx_reg <= 8'h00;
				sum_reg  <= 8'h00;
				if (TF_DATA_I == `CMD_IDENTIFY) begin
					state_reg <= ST_ID;
					BUSY_O    <= 1'b1;
				end else if (TF_DATA_I == `CMD_INIT_PARAMS) begin
					cur_heads_reg <= {12'h000, drive_head_select_reg[`HEAD_MSB:`HEAD_LSB]}
						+ 16'h0001;
					cur_spt_reg   <= {8'h00, transfer_length_reg};
				end else if (TF_DATA_I == `CMD_HEALTH) begin
					case (feature_reg)
					`SUB_READ_DATA, `SUB_READ_THRESH: begin
						if (HEALTH_ON_O) begin
							state_reg  <= ST_HLTH;
							BUSY_O     <= 1'b1;
							thresh_reg <= (feature_reg == `SUB_READ_THRESH);
						end else begin
							ERR_O   <= 1'b1;
							ABORT_O <= 1'b1;
						end
					end
					`SUB_AUTOSAVE, `SUB_SAVE_ATTR: begin
						ERR_O   <= !HEALTH_ON_O;
						ABORT_O <= !HEALTH_ON_O;
					end
					`SUB_OFFLINE_NOW: begin
						if (HEALTH_ON_O)
							offline_status_reg <= `OFF_DONE;
						ERR_O   <= !HEALTH_ON_O;
						ABORT_O <= !HEALTH_ON_O;
					end
					`SUB_ENABLE:  HEALTH_ON_O <= 1'b1;
					`SUB_DISABLE: HEALTH_ON_O <= 1'b0;
					`SUB_RET_STATUS: begin
						if (HEALTH_ON_O) begin
							CYL_LOW_O  <= SPARE_LOW_I ? `CYL_LOW_LOW : `CYL_LOW_GOOD;
							CYL_HIGH_O <= SPARE_LOW_I ? `CYL_HIGH_LOW : `CYL_HIGH_GOOD;
						end
						ERR_O   <= !HEALTH_ON_O;
						ABORT_O <= !HEALTH_ON_O;
					end
					default: begin
						ERR_O   <= 1'b1;
						ABORT_O <= 1'b1;
					end
					endcase
				end
			end
			// Busy drops with the last push, while the FIFO may still hold words.
			if (push) begin
				widx_reg <= widx_reg + 8'h01;
				sum_reg  <= sum_reg + word_next[7:0] + word_next[15:8];
				if (widx_reg == `WORD_LAST) begin
					state_reg <= ST_IDLE;
					BUSY_O    <= 1'b0;
				end
			end
		end
	end

	word_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk_i       (REF_CLK_I),
		.rst_i       (RST_I),
		.in_data_i   (word_next),
		.in_valid_i  (state_reg != ST_IDLE),
		.in_ready_o  (fifo_ready),
		.out_data_o  (DATA_O),
		.out_valid_o (DATA_VALID_O),
		.out_ready_i (DATA_READY_I)
	);
endmodule // ata_smart_identify_responder
